// ### core/timer16_defs.vh
// Constants for the 16-bit timer mode and capture/compare control block
// What this block does
// - Reset loads the timer mode register with zero, so the counter stands stopped.
// - Counting starts when run mode turns nonzero and stops when written zero.
// - Run mode zero disables counting, gates the count clock, clears counter circuitry.
// - Run mode 01 free-run, 10 clear on trigger A edge, 11 clear on match A.
// - Output inverts on match A or B; toggle bit adds trigger A valid edges.
// - Overflow flag sets in every running mode when the count wraps max to zero.
// - Overflow flag clears on a software write of 0 or on stop.
// - A software write of 1 sets the overflow flag unless the same write sets run mode zero.
// - Trigger A valid edge comes from prescaler register bits five and four.
// - Reset clears the capture/compare control register, both registers compare.
// - Control bit 2 selects capture (1) or compare (0) for register B.
// - Trigger select 0: A captures on B valid edge; 1: opposite edge of A.
// - Both-edge trigger A with reverse phase selected detects no valid A edge.
// - Control bit 0 selects capture (1) or compare (0) for register A.
// - Reverse phase: B valid edge captures nothing, raises register A interrupt instead.
// - Control registers accept whole-byte writes only, gated by byteenable[0].
// - Count increments by one on each count clock tick while running.
// - Compare registers match against the count only on count clock ticks and raise their interrupt.
// - Count register reads zero while run mode is zero.
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_TMR_B_MODE   16'hffb6
`define IDX_TMR_A_MODE   16'hffba
`define IDX_CC_CTRL      16'hffbc
`define IDX_PRESCALE     16'hffbb
`define IDX_COUNT        16'hff10
`define IDX_CC_A         16'hff12
`define IDX_CC_B         16'hff14

// Timer mode register fields
`define RUN_HI           3
`define RUN_LO           2
`define TOGGLE_BIT       1
`define OVF_BIT          0
`define TMC_MASK         8'h0f

// Capture/compare control fields
`define CAP_B_BIT        2
`define TRIG_SEL_BIT     1
`define CAP_A_BIT        0
`define CRC_MASK         8'h07

// Prescaler edge select fields
`define ES_A_HI          5
`define ES_A_LO          4
`define ES_B_HI          7
`define ES_B_LO          6

// Run modes
`define MODE_STOP        2'b00
`define MODE_FREE        2'b01
`define MODE_CLR_EDGE    2'b10
`define MODE_CLR_MATCH   2'b11

// Edge select codes
`define EDGE_FALL        2'b00
`define EDGE_RISE        2'b01
`define EDGE_BOTH        2'b11

// Reset and limit values
`define CTRL_RST         8'h00
`define COUNT_RST        16'h0000
`define COUNT_MAX        16'hffff
`define COUNT_ONE        16'h0001
`define RDATA_RST        32'h00000000

`endif

// ### core/trigger_edge.v
// Edge detector for one timer trigger input
`timescale 1ns/1ns
`include "timer16_defs.vh"

module trigger_edge
(
   // Clock and reset
   input  wire       clk_sys,
   input  wire       arst_n,
   input  wire       ce,
   // Control
   input  wire       run,
   input  wire [1:0] edge_sel,
   // Trigger
   input  wire       din,
   output wire       valid_edge,
   output wire       reverse_edge
);

   reg  prev;
   wire rise;
   wire fall;

   function edge_hit;
      input [1:0] sel;
      input       r;
      input       f;
      begin
         case (sel)
            `EDGE_FALL: edge_hit = f;
            `EDGE_RISE: edge_hit = r;
            `EDGE_BOTH: edge_hit = r | f;
            default:    edge_hit = 1'b0;
         endcase
      end
   endfunction

   // Cleared while stopped, so a high input shows as a rising edge on restart
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         prev <= 1'b0;
      else if (ce)
         prev <= run ? din : 1'b0;
   end

   assign rise = run & din & ~prev;
   assign fall = run & ~din & prev;

   assign valid_edge   = edge_hit(edge_sel, rise, fall);
   // Opposite edge only; both-edge select leaves nothing
   assign reverse_edge = (edge_sel == `EDGE_RISE) ? fall :
                         (edge_sel == `EDGE_FALL) ? rise : 1'b0;

endmodule // trigger_edge

// ### core/timer16_mode_capture_control.v
// 16-bit timer with mode, capture/compare control and Avalon-MM registers
`timescale 1ns/1ns
`include "timer16_defs.vh"

module timer16_mode_capture_control
(
   // Clock and reset
   input  wire        clk_sys,
   input  wire        arst_n,
   input  wire        ce,
   // Avalon-MM slave
   input  wire [17:0] address,
   input  wire        read,
   input  wire        write,
   input  wire [3:0]  byteenable,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   // Timer pins
   input  wire        count_tick,
   input  wire        trigger_input_a,
   input  wire        trigger_input_b,
   output reg         toggle_output_pin,
   // Interrupt requests
   output reg         reg_a_irq,
   output reg         reg_b_irq
);

   localparam BUS_IDLE = 1'b0;
   localparam BUS_ACK  = 1'b1;

   // Software-visible state and bus handshake state
   reg  [7:0]  timer_a_mode_control;
   reg  [7:0]  timer_b_mode_control;
   reg  [7:0]  timer_a_capture_compare_control;
   reg  [7:0]  prescaler_select_reg;
   reg  [15:0] count_register;
   reg  [15:0] capture_compare_reg_a;
   reg  [15:0] capture_compare_reg_b;
   reg         bus_state;

   wire [15:0] index;
   wire        wr_now;
   wire [1:0]  run_mode;
   wire        running;
   wire        toggle_condition_bit;
   wire        overflow_flag;
   wire        reg_b_capture_select;
   wire        reg_a_trigger_select;
   wire        reg_a_capture_select;
   wire [1:0]  edge_sel [0:1];
   wire        trig_in [0:1];
   wire        valid_raw [0:1];
   wire        reverse_raw [0:1];
   wire        valid_a;
   wire        valid_b;
   wire        rev_a;
   wire        tick;
   wire        match_a;
   wire        match_b;
   wire        clear_start;
   wire        wrap;
   wire        cap_a;
   wire        cap_b;
   wire        irq_a_event;
   wire        toggle_event;
   wire [7:0]  next_tmc_a;
   wire [7:0]  next_tmc_b;
   reg  [31:0] next_readdata;

   function hit;
      input [15:0] idx;
      input [15:0] want;
      begin
         hit = (idx == want);
      end
   endfunction

   assign index  = address[17:2];
   // Write lands at the edge where waitrequest is seen low
   assign wr_now = write & (bus_state == BUS_ACK) & byteenable[0];

   assign run_mode             = {timer_a_mode_control[`RUN_HI], timer_a_mode_control[`RUN_LO]};
   assign running              = (run_mode != `MODE_STOP);
   assign toggle_condition_bit = timer_a_mode_control[`TOGGLE_BIT];
   assign overflow_flag        = timer_a_mode_control[`OVF_BIT];
   assign reg_b_capture_select = timer_a_capture_compare_control[`CAP_B_BIT];
   assign reg_a_trigger_select = timer_a_capture_compare_control[`TRIG_SEL_BIT];
   assign reg_a_capture_select = timer_a_capture_compare_control[`CAP_A_BIT];

   assign edge_sel[0] = {prescaler_select_reg[`ES_A_HI], prescaler_select_reg[`ES_A_LO]};
   assign edge_sel[1] = {prescaler_select_reg[`ES_B_HI], prescaler_select_reg[`ES_B_LO]};
   assign trig_in[0]  = trigger_input_a;
   assign trig_in[1]  = trigger_input_b;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : gen_trig
         trigger_edge u_edge
         (
            .clk_sys      (clk_sys),
            .arst_n       (arst_n),
            .ce           (ce),
            .run          (running),
            .edge_sel     (edge_sel[g]),
            .din          (trig_in[g]),
            .valid_edge   (valid_raw[g]),
            .reverse_edge (reverse_raw[g])
         );
      end
   endgenerate

   // Both-edge select with reverse phase hides the A valid edge
   assign valid_a = valid_raw[0] & ~(reg_a_trigger_select & (edge_sel[0] == `EDGE_BOTH));
   assign valid_b = valid_raw[1];
   assign rev_a   = reverse_raw[0] & reg_a_trigger_select;

   // Count clock is gated while stopped
   assign tick    = running & count_tick;

   // Match counted once per count period, at its closing tick
   assign match_a = tick & ~reg_a_capture_select & (count_register == capture_compare_reg_a);
   assign match_b = tick & ~reg_b_capture_select & (count_register == capture_compare_reg_b);

   assign clear_start = ((run_mode == `MODE_CLR_EDGE) & valid_a) |
                        ((run_mode == `MODE_CLR_MATCH) & match_a);
   assign wrap        = tick & ~clear_start & (count_register == `COUNT_MAX);

   // Capture sources
   assign cap_a = running & reg_a_capture_select &
                  (reg_a_trigger_select ? rev_a : valid_b);
   assign cap_b = running & reg_b_capture_select & valid_a;

   // Reverse phase: capture is silent, B edge becomes external request
   assign irq_a_event = match_a |
                        (cap_a & ~reg_a_trigger_select) |
                        (running & reg_a_capture_select & reg_a_trigger_select & valid_b);

   assign toggle_event = match_a | match_b | (toggle_condition_bit & valid_a);

   // Mode register write: stop clears flag, hardware overflow wins over clear
   assign next_tmc_a = {4'h0, writedata[`RUN_HI:`TOGGLE_BIT],
                        ((writedata[`RUN_HI:`RUN_LO] != `MODE_STOP) &
                         (writedata[`OVF_BIT] | wrap))} & `TMC_MASK;
   assign next_tmc_b = {4'h0, writedata[`RUN_HI:`TOGGLE_BIT],
                        ((writedata[`RUN_HI:`RUN_LO] != `MODE_STOP) &
                         writedata[`OVF_BIT])} & `TMC_MASK;

   // Bus handshake: one wait cycle, answer on the second
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_state   <= BUS_IDLE;
         waitrequest <= 1'b1;
         readdata    <= `RDATA_RST;
      end
      else if (ce)
      begin
         case (bus_state)
            BUS_IDLE:
            begin
               if (read | write)
               begin
                  bus_state   <= BUS_ACK;
                  waitrequest <= 1'b0;
                  readdata    <= next_readdata;
               end
            end
            BUS_ACK:
            begin
               bus_state   <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default:
            begin
               bus_state   <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Read mux; unmapped reads return zero
   always @*
   begin
      next_readdata = `RDATA_RST;
      if (read)
      begin
         if (hit(index, `IDX_TMR_A_MODE))
            next_readdata[7:0] = timer_a_mode_control;
         else if (hit(index, `IDX_TMR_B_MODE))
            next_readdata[7:0] = timer_b_mode_control;
         else if (hit(index, `IDX_CC_CTRL))
            next_readdata[7:0] = timer_a_capture_compare_control;
         else if (hit(index, `IDX_PRESCALE))
            next_readdata[7:0] = prescaler_select_reg;
         else if (hit(index, `IDX_COUNT))
            next_readdata[15:0] = running ? count_register : `COUNT_RST;
         else if (hit(index, `IDX_CC_A))
            next_readdata[15:0] = capture_compare_reg_a;
         else if (hit(index, `IDX_CC_B))
            next_readdata[15:0] = capture_compare_reg_b;
      end
   end

   // Control registers
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timer_a_mode_control            <= `CTRL_RST;
         timer_b_mode_control            <= `CTRL_RST;
         timer_a_capture_compare_control <= `CTRL_RST;
         prescaler_select_reg            <= `CTRL_RST;
      end
      else if (ce)
      begin
         if (wr_now & hit(index, `IDX_TMR_A_MODE))
            timer_a_mode_control <= next_tmc_a;
         else if (wrap)
            timer_a_mode_control[`OVF_BIT] <= 1'b1;
         if (wr_now & hit(index, `IDX_TMR_B_MODE))
            timer_b_mode_control <= next_tmc_b;
         if (wr_now & hit(index, `IDX_CC_CTRL))
            timer_a_capture_compare_control <= writedata[7:0] & `CRC_MASK;
         if (wr_now & hit(index, `IDX_PRESCALE))
            prescaler_select_reg <= writedata[7:0];
      end
   end

   // Counter: cleared while stopped, clear & start, wrap on overflow
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         count_register <= `COUNT_RST;
      else if (ce)
      begin
         if (!running)
            count_register <= `COUNT_RST;
         else if (clear_start)
            count_register <= `COUNT_RST;
         else if (tick)
            count_register <= count_register + `COUNT_ONE;
      end
   end

   // Capture/compare registers; capture beats software write
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         capture_compare_reg_a <= `COUNT_RST;
         capture_compare_reg_b <= `COUNT_RST;
      end
      else if (ce)
      begin
         if (cap_a)
            capture_compare_reg_a <= count_register;
         else if (write & (bus_state == BUS_ACK) & hit(index, `IDX_CC_A))
         begin
            if (byteenable[0])
               capture_compare_reg_a[7:0] <= writedata[7:0];
            if (byteenable[1])
               capture_compare_reg_a[15:8] <= writedata[15:8];
         end
         if (cap_b)
            capture_compare_reg_b <= count_register;
         else if (write & (bus_state == BUS_ACK) & hit(index, `IDX_CC_B))
         begin
            if (byteenable[0])
               capture_compare_reg_b[7:0] <= writedata[7:0];
            if (byteenable[1])
               capture_compare_reg_b[15:8] <= writedata[15:8];
         end
      end
   end

   // Output pin and interrupt pulses
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         toggle_output_pin <= 1'b0;
         reg_a_irq         <= 1'b0;
         reg_b_irq         <= 1'b0;
      end
      else if (ce)
      begin
         if (toggle_event)
            toggle_output_pin <= ~toggle_output_pin;
         reg_a_irq <= irq_a_event;
         reg_b_irq <= match_b | cap_b;
      end
   end

endmodule // timer16_mode_capture_control

// ### dv/tcc_chk_assertions.sv
// Concurrent checks on the timer block ports
`timescale 1ns/1ns
module tcc_chk
(
   // Clock, reset, bus
   input wire        clk_sys, arst_n, ce, read, write, waitrequest,
   input wire [17:0] address,
   input wire [3:0]  byteenable,
   input wire [31:0] writedata, readdata,
   // Timer pins
   input wire        count_tick, trigger_input_a, trigger_input_b,
   input wire        toggle_output_pin, reg_a_irq, reg_b_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   reg [1:0] run_mode;
   wire      rd_ack = read && !waitrequest;
   // Shadow of the run mode field, tracked from acknowledged writes
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         run_mode <= 2'b00;
      else if (write && !waitrequest && address[17:2] == 16'hffba && byteenable[0])
         run_mode <= writedata[3:2];
   property p_ack; ce && (read || write) && waitrequest |=> !waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("request not answered in one cycle");
   property p_one; !waitrequest |=> waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer held over two cycles");
   property p_cause; !waitrequest |-> $past(read) || $past(write); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_rst; !$past(arst_n) |-> waitrequest && readdata == 32'h00000000; endproperty
   a_rst: assert property (p_rst) else $error("bus not idle after reset");
   property p_cnt; rd_ack && address[17:2] == 16'hff10 && run_mode == 2'b00 |-> readdata[15:0] == 16'h0000;
   endproperty
   a_cnt: assert property (p_cnt) else $error("count nonzero while stopped");
   property p_ovf; rd_ack && address[17:2] == 16'hffba && run_mode == 2'b00 |-> !readdata[0]; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag set while stopped");
   property p_irqa; reg_a_irq |=> !reg_a_irq; endproperty
   a_irqa: assert property (p_irqa) else $error("irq a longer than one cycle");
   property p_irqb; reg_b_irq |=> !reg_b_irq; endproperty
   a_irqb: assert property (p_irqb) else $error("irq b longer than one cycle");
   property p_stop; reg_a_irq || reg_b_irq |-> run_mode != 2'b00 || $past(run_mode) != 2'b00; endproperty
   a_stop: assert property (p_stop) else $error("irq while stopped");
   property p_tog;
      $changed(toggle_output_pin) |-> reg_a_irq || reg_b_irq ||
         $past(trigger_input_a, 1) != $past(trigger_input_a, 4);
   endproperty
   a_tog: assert property (p_tog) else $error("toggle without cause");
   c_irqa: cover property (reg_a_irq);
   c_irqb: cover property (reg_b_irq);
   c_tog: cover property ($changed(toggle_output_pin));
endmodule // tcc_chk
bind timer16_mode_capture_control tcc_chk u_chk
(
   .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .read(read), .write(write),
   .waitrequest(waitrequest), .address(address), .byteenable(byteenable),
   .writedata(writedata), .readdata(readdata), .count_tick(count_tick),
   .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
   .toggle_output_pin(toggle_output_pin), .reg_a_irq(reg_a_irq), .reg_b_irq(reg_b_irq)
);

// ### dv/trig_src.sv
// Far-side model: trigger pulse sources
`timescale 1ns/1ns
module trig_src
#(
   parameter WIDTH = 4
)
(
   // Clock and reset
   input wire clk_sys, arst_n,
   // Pulse requests
   input wire fire_a, fire_b,
   // Trigger lines
   output reg trigger_input_a, trigger_input_b
);
   reg [3:0] cnt_a, cnt_b;
   // Pulses stay high for WIDTH clock cycles
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         trigger_input_a <= 1'b0;
         trigger_input_b <= 1'b0;
         cnt_a <= 4'h0;
         cnt_b <= 4'h0;
      end
      else
      begin
         if (fire_a)
         begin
            trigger_input_a <= 1'b1;
            cnt_a <= WIDTH;
         end
         else if (cnt_a != 4'h0)
         begin
            cnt_a <= cnt_a - 4'h1;
            if (cnt_a == 4'h1) trigger_input_a <= 1'b0;
         end
         if (fire_b)
         begin
            trigger_input_b <= 1'b1;
            cnt_b <= WIDTH;
         end
         else if (cnt_b != 4'h0)
         begin
            cnt_b <= cnt_b - 4'h1;
            if (cnt_b == 4'h1) trigger_input_b <= 1'b0;
         end
      end
endmodule // trig_src

// ### dv/tb_timer16_mode_capture_control.sv
// Self-checking bench for the timer mode and capture/compare block
`timescale 1ns/1ns
module tb_timer16_mode_capture_control;
   reg         clk_sys = 0, arst_n = 0, read = 0, write = 0, fire_a = 0, fire_b = 0, count_tick = 0;
   reg  [17:0] address = 0;
   reg  [3:0]  byteenable = 0;
   reg  [31:0] writedata = 0, rd;
   wire [31:0] readdata;
   wire        waitrequest, trigger_input_a, trigger_input_b, toggle_output_pin, reg_a_irq, reg_b_irq;
   integer     bad_count = 0, compares = 0;
   reg         tog0;
   timer16_mode_capture_control dut
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .count_tick(count_tick), .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
      .toggle_output_pin(toggle_output_pin), .reg_a_irq(reg_a_irq), .reg_b_irq(reg_b_irq)
   );
   trig_src #(.WIDTH(4)) far
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .fire_a(fire_a), .fire_b(fire_b),
      .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b)
   );
   initial forever #5 clk_sys = ~clk_sys;
   task complete_run;
   begin
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task bus(input w, input [15:0] idx, input [31:0] d);
      integer n;
   begin
      @(posedge clk_sys);
      address <= {idx, 2'b00};
      writedata <= d;
      write <= w;
      read <= !w;
      byteenable <= 4'hf;
      n = 0;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0)
      begin
         n = n + 1;
         if (n > 20)
         begin
            bad_count = bad_count + 1;
            complete_run;
         end
         @(posedge clk_sys);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   end
   endtask
   task rdck(input [15:0] idx, input [31:0] exp);
   begin
      bus(1'b0, idx, 32'h0);
      chk(rd, exp);
   end
   endtask
   task wirq(input b);
      integer n;
      reg s;
   begin
      s = 1'b0;
      for (n = 0; n < 300 && !s; n = n + 1)
      begin
         @(posedge clk_sys);
         #1;
         s = b ? reg_b_irq === 1'b1 : reg_a_irq === 1'b1;
      end
      chk({31'h0, s}, 32'h1);
   end
   endtask
   task fire(input b);
   begin
      @(posedge clk_sys);
      if (b) fire_b <= 1'b1; else fire_a <= 1'b1;
      @(posedge clk_sys);
      fire_a <= 1'b0;
      fire_b <= 1'b0;
   end
   endtask
   task t_reset;
   begin
      rdck(16'hffba, 32'h0);
      rdck(16'hffb6, 32'h0);
      rdck(16'hffbc, 32'h0);
      rdck(16'hff10, 32'h0);
      bus(1'b1, 16'h0000, 32'hff);
      rdck(16'h0000, 32'h0);
      bus(1'b1, 16'hffbc, 32'hff);
      rdck(16'hffbc, 32'h07);
      $display("test reset done");
   end
   endtask
   task t_flag;
   begin
      bus(1'b1, 16'hffba, 32'h05);
      rdck(16'hffba, 32'h05);
      bus(1'b1, 16'hffba, 32'h04);
      rdck(16'hffba, 32'h04);
      bus(1'b1, 16'hffba, 32'h01);
      rdck(16'hffba, 32'h00);
      bus(1'b1, 16'hffbc, 32'h00);
      $display("test flag done");
   end
   endtask
   task t_wrap;
   begin
      bus(1'b1, 16'hffba, 32'h04);
      repeat (65540) @(posedge clk_sys);
      rdck(16'hffba, 32'h05);
      bus(1'b0, 16'hff10, 32'h0);
      chk(rd < 300, 32'h1);
      bus(1'b1, 16'hffba, 32'h00);
      rdck(16'hff10, 32'h0);
      rdck(16'hffba, 32'h0);
      $display("test wrap done");
   end
   endtask
   task t_match;
   begin
      bus(1'b1, 16'hff12, 32'h5);
      bus(1'b1, 16'hff14, 32'h10);
      tog0 = toggle_output_pin;
      bus(1'b1, 16'hffba, 32'h04);
      wirq(1'b0);
      chk(toggle_output_pin, !tog0);
      wirq(1'b1);
      chk(toggle_output_pin, tog0);
      bus(1'b1, 16'hffba, 32'h00);
      bus(1'b1, 16'hffba, 32'h0c);
      wirq(1'b0);
      wirq(1'b0);
      bus(1'b0, 16'hff10, 32'h0);
      chk(rd < 6, 32'h1);
      bus(1'b1, 16'hffba, 32'h00);
      $display("test match done");
   end
   endtask
   task t_edge;
   begin
      bus(1'b1, 16'hff12, 32'h7000);
      bus(1'b1, 16'hffbb, 32'h10);
      bus(1'b1, 16'hffbc, 32'h04);
      tog0 = toggle_output_pin;
      bus(1'b1, 16'hffba, 32'h0a);
      repeat (50) @(posedge clk_sys);
      fire(1'b0);
      repeat (10) @(posedge clk_sys);
      chk(toggle_output_pin, !tog0);
      bus(1'b0, 16'hff10, 32'h0);
      chk(rd < 30, 32'h1);
      bus(1'b0, 16'hff14, 32'h0);
      chk(rd >= 40 && rd < 80, 32'h1);
      bus(1'b1, 16'hffba, 32'h00);
      $display("test edge done");
   end
   endtask
   task t_rev;
   begin
      bus(1'b1, 16'hffbb, 32'h50);
      bus(1'b1, 16'hffbc, 32'h03);
      bus(1'b1, 16'hffba, 32'h04);
      repeat (20) @(posedge clk_sys);
      fire(1'b1);
      wirq(1'b0);
      rdck(16'hff12, 32'h7000);
      fire(1'b0);
      repeat (12) @(posedge clk_sys);
      bus(1'b0, 16'hff12, 32'h0);
      chk(rd < 200, 32'h1);
      bus(1'b1, 16'hffba, 32'h00);
      bus(1'b1, 16'hff12, 32'h7000);
      bus(1'b1, 16'hffbb, 32'h30);
      bus(1'b1, 16'hffba, 32'h04);
      fire(1'b0);
      repeat (12) @(posedge clk_sys);
      rdck(16'hff12, 32'h7000);
      bus(1'b1, 16'hffba, 32'h00);
      $display("test reverse done");
   end
   endtask
   initial
   begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      count_tick <= 1'b1;
      t_reset;
      t_flag;
      t_wrap;
      t_match;
      t_edge;
      t_rev;
      complete_run;
   end
endmodule // tb_timer16_mode_capture_control
